// ==== design/ifr_pkg.sv ====
// Constants and types shared by the input function router.
//
// Summary of operation
// R1: Four base inputs, each with own selector.
// R2: Inputs sharing a function are ORed.
// R3: Selector codes decoded; input one defaults run.
// R4: Stop is active low, stop inputs ANDed.
// R5: Normal reset on edge, auto reset level.
// R6: Enable low cuts output; enables ANDed.
// R7: No enable input means enable held asserted.
// R8: Jog inputs always act on level.
// R9: Two select bits choose sets A to D.
// R10: Set selection only when source is inputs.
// R11: Local/remote input selects local mode.
// R12: Analogue gate input gates analogue input.
// R13: Autoset always acts on rising edge.
// R14: Spin brake accepted while stopped and rotating.
// R15: Alarm one active low, inputs ORed.
// R16: Alarm two active low.
// R17: Timer inputs start timers on rising edge.
// R18: Option board inputs behave like base inputs.
// R19: Inputs two to four default stop, set bit 0, reset.
// R20: Analogue gate config: always, low, high.
// R21: Inputs synchronised; edges from previous sample.
package ifr_pkg;

    // ****************************************************************
    // Input counts
    // ****************************************************************
    localparam int unsigned IFR_NUM_BASE = 4;
    localparam int unsigned IFR_NUM_BOARDS = 2;
    localparam int unsigned IFR_PER_BOARD = 3;
    localparam int unsigned IFR_NUM_IN = IFR_NUM_BASE + IFR_NUM_BOARDS * IFR_PER_BOARD;
    localparam int unsigned IFR_CODE_W = 5;
    localparam int unsigned IFR_IDX_W = 4;

    typedef logic [IFR_CODE_W-1:0] ifr_code_t;
    typedef logic [IFR_NUM_IN-1:0] ifr_vec_t;

    // ****************************************************************
    // Function codes
    // ****************************************************************
    localparam ifr_code_t IFR_FN_OFF = 5'h00;
    localparam ifr_code_t IFR_FN_STOP = 5'h01;
    localparam ifr_code_t IFR_FN_RESET = 5'h02;
    localparam ifr_code_t IFR_FN_ENABLE = 5'h03;
    localparam ifr_code_t IFR_FN_RUN_FORWARD_CMD = 5'h04;
    localparam ifr_code_t IFR_FN_RUN_REVERSE_CMD = 5'h05;
    localparam ifr_code_t IFR_FN_INCH_FWD = 5'h06;
    localparam ifr_code_t IFR_FN_INCH_REV = 5'h07;
    localparam ifr_code_t IFR_FN_SET_BIT0 = 5'h08;
    localparam ifr_code_t IFR_FN_SET_BIT1 = 5'h09;
    localparam ifr_code_t IFR_FN_LOCAL = 5'h0A;
    localparam ifr_code_t IFR_FN_ANALOG_GATE = 5'h0B;
    localparam ifr_code_t IFR_FN_AUTOSET = 5'h0C;
    localparam ifr_code_t IFR_FN_SPIN_BRAKE = 5'h0D;
    localparam ifr_code_t IFR_FN_ALARM1 = 5'h10;
    localparam ifr_code_t IFR_FN_ALARM2 = 5'h11;
    localparam ifr_code_t IFR_FN_TIMER1 = 5'h12;

    // ****************************************************************
    // Reset values of the selectors, the enable and the analogue active output
    // ****************************************************************
    localparam ifr_code_t IFR_DEF_SEL0 = IFR_FN_RUN_FORWARD_CMD;
    localparam ifr_code_t IFR_DEF_SEL1 = IFR_FN_STOP;
    localparam ifr_code_t IFR_DEF_SEL2 = IFR_FN_SET_BIT0;
    localparam ifr_code_t IFR_DEF_SEL3 = IFR_FN_RESET;
    localparam ifr_code_t IFR_DEF_SEL_BOARD = IFR_FN_OFF;
    localparam logic IFR_RST_ENABLE = 1'h1;
    localparam logic IFR_RST_ANALOG = 1'h1;

    // ****************************************************************
    // Analogue gate configuration
    // ****************************************************************
    localparam logic [1:0] IFR_AG_ALWAYS = 2'h0;
    localparam logic [1:0] IFR_AG_WHEN_LOW = 2'h1;
    localparam logic [1:0] IFR_AG_WHEN_HIGH = 2'h2;

    localparam int unsigned IFR_NUM_TIMERS = 4;

endpackage : ifr_pkg

// ==== design/ifr_input_function_router.sv ====
// Input function router: maps discrete inputs to starter command functions.
`timescale 1ns/1ps

module ifr_input_function_router (
    input wire logic i_sys_clk, // System clock, 25 MHz
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic [ifr_pkg::IFR_NUM_IN-1:0] i_discrete_input, // 0-3 base, 4-9 boards
    input wire logic [ifr_pkg::IFR_NUM_BOARDS-1:0] i_board_fitted, // Option board present
    input wire logic i_sel_wr, // Selector write strobe
    input wire logic [ifr_pkg::IFR_IDX_W-1:0] i_sel_index, // Selector to write
    input wire logic [ifr_pkg::IFR_CODE_W-1:0] i_sel_code, // Function code to write
    input wire logic i_edge_mode, // 1: run commands edge triggered
    input wire logic i_auto_reset_on, // Auto reset function enabled
    input wire logic i_set_src_inputs, // Set source is the inputs
    input wire logic [1:0] i_param_set_other, // Set chosen by other source
    input wire logic [1:0] i_analog_gate_config, // Analogue gate mode
    input wire logic i_motor_rotating, // Motor still turning
    output logic o_stop_req, // Stop requested
    output logic o_trip_reset_pulse, // Normal trip reset, one cycle
    output logic o_auto_reset_req, // Auto reset level
    output logic o_enable, // Internal enable
    output logic o_run_forward_cmd, // Run forward
    output logic o_run_reverse_cmd, // Run reverse
    output logic o_inch_forward_cmd, // Jog forward
    output logic o_inch_reverse_cmd, // Jog reverse
    output logic [1:0] o_param_set, // 0=A 1=B 2=C 3=D
    output logic o_local_mode, // Local control mode
    output logic o_analog_active, // Analogue input active
    output logic o_autoset_pulse, // Autoset trigger, one cycle
    output logic o_spin_brake_req, // Spin brake request
    output logic o_ext_alarm1, // External alarm 1 trip
    output logic o_ext_alarm2, // External alarm 2 trip
    output logic [ifr_pkg::IFR_NUM_TIMERS-1:0] o_timer_start // Timer start pulses
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        // Input pipeline and selectors
        ifr_pkg::ifr_vec_t sync1;
        ifr_pkg::ifr_vec_t sync2;
        ifr_pkg::ifr_vec_t prev;
        logic [ifr_pkg::IFR_NUM_IN-1:0][ifr_pkg::IFR_CODE_W-1:0] sel;

        // Registered outputs
        logic stop_req;
        logic trip_reset_pulse;
        logic auto_reset_req;
        logic enable;
        logic run_forward_cmd;
        logic run_reverse_cmd;
        logic inch_fwd;
        logic inch_rev;
        logic [1:0] param_set;
        logic local_mode;
        logic analog_active;
        logic autoset_pulse;
        logic spin_brake_req;
        logic alarm1;
        logic alarm2;
        logic [ifr_pkg::IFR_NUM_TIMERS-1:0] timer_start;
    } ifr_state_t;

    ifr_state_t state_reg;
    ifr_state_t state_next;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Mask of inputs carrying a function; unfitted board inputs never match
    // Scans all selectors per function: small and regular, no shared decoder
    function automatic ifr_pkg::ifr_vec_t fn_mask(
        input logic [ifr_pkg::IFR_NUM_IN-1:0][ifr_pkg::IFR_CODE_W-1:0] sel,
        input ifr_pkg::ifr_code_t code,
        input logic [ifr_pkg::IFR_NUM_BOARDS-1:0] fitted
    );
        ifr_pkg::ifr_vec_t m;
        m = '0;
        for (int i = 0; i < ifr_pkg::IFR_NUM_IN; i++) begin
            if (sel[i] == code) begin
                if (i < ifr_pkg::IFR_NUM_BASE) begin
                    m[i] = 1'h1;
                end else begin
                    m[i] = fitted[(i - ifr_pkg::IFR_NUM_BASE) / ifr_pkg::IFR_PER_BOARD]; // [R18]
                end
            end
        end
        return m;
    endfunction : fn_mask

    // OR of the selected bits
    function automatic logic fn_any(
        input ifr_pkg::ifr_vec_t m,
        input ifr_pkg::ifr_vec_t v
    );
        return |(m & v);
    endfunction : fn_any

    // AND of the selected bits; true when no input is selected
    function automatic logic fn_all(
        input ifr_pkg::ifr_vec_t m,
        input ifr_pkg::ifr_vec_t v
    );
        return &(~m | v);
    endfunction : fn_all

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        ifr_pkg::ifr_vec_t lvl;
        ifr_pkg::ifr_vec_t rise;
        ifr_pkg::ifr_vec_t m;
        logic gate_in;
        logic [1:0] set_in;
        lvl = '0;
        rise = '0;
        m = '0;
        gate_in = 1'h0;
        set_in = 2'h0;
        state_next = state_reg;

        // ****************************************
        // Input sampling
        // ****************************************
        // Two flops against metastability; edges use the second only
        state_next.sync1 = i_discrete_input; // [R21]
        state_next.sync2 = state_reg.sync1; // [R21]
        state_next.prev = state_reg.sync2; // [R21]
        lvl = state_reg.sync2;
        rise = state_reg.sync2 & ~state_reg.prev; // [R21]

        // ****************************************
        // Selector writes
        // ****************************************
        // Out-of-range index dropped silently: no status bit reports it
        if (i_sel_wr && (i_sel_index < ifr_pkg::IFR_IDX_W'(ifr_pkg::IFR_NUM_IN))) begin
            state_next.sel[i_sel_index] = i_sel_code; // [R1] [R18]
        end

        // ****************************************
        // Stop
        // ****************************************
        // Any stop input low stops; inputs ANDed as permission
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_STOP, i_board_fitted);
        state_next.stop_req = ~fn_all(m, lvl); // [R4]

        // ****************************************
        // Trip reset
        // ****************************************
        // Normal reset on edge only, so a held contact resets once
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_RESET, i_board_fitted);
        state_next.trip_reset_pulse = fn_any(m, rise); // [R5] [R2]
        state_next.auto_reset_req = i_auto_reset_on & fn_any(m, lvl); // [R5]

        // ****************************************
        // Enable
        // ****************************************
        // ANDed; no enable input leaves it asserted
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_ENABLE, i_board_fitted);
        state_next.enable = fn_all(m, lvl); // [R6] [R7]

        // ****************************************
        // Run and jog commands
        // ****************************************
        // Run commands follow the global trigger mode
        if (i_edge_mode) begin
            m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_RUN_FORWARD_CMD, i_board_fitted);
            state_next.run_forward_cmd = fn_any(m, rise); // [R2] [R3]
            m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_RUN_REVERSE_CMD, i_board_fitted);
            state_next.run_reverse_cmd = fn_any(m, rise); // [R2] [R3]
        end else begin
            m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_RUN_FORWARD_CMD, i_board_fitted);
            state_next.run_forward_cmd = fn_any(m, lvl); // [R2] [R3]
            m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_RUN_REVERSE_CMD, i_board_fitted);
            state_next.run_reverse_cmd = fn_any(m, lvl); // [R2] [R3]
        end

        // Jog ignores edge mode on purpose: release must stop at once
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_INCH_FWD, i_board_fitted);
        state_next.inch_fwd = fn_any(m, lvl); // [R8]
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_INCH_REV, i_board_fitted);
        state_next.inch_rev = fn_any(m, lvl); // [R8]

        // ****************************************
        // Parameter set
        // ****************************************
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_SET_BIT0, i_board_fitted);
        set_in[0] = fn_any(m, lvl); // [R9]
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_SET_BIT1, i_board_fitted);
        set_in[1] = fn_any(m, lvl); // [R9]
        if (i_set_src_inputs) begin
            state_next.param_set = set_in; // [R10]
        end else begin
            // Other source owns the selection; input bits ignored
            state_next.param_set = i_param_set_other; // [R10]
        end

        // ****************************************
        // Local mode
        // ****************************************
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_LOCAL, i_board_fitted);
        state_next.local_mode = fn_any(m, lvl); // [R11]

        // ****************************************
        // Analogue gate
        // ****************************************
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_ANALOG_GATE, i_board_fitted);
        gate_in = fn_any(m, lvl); // [R12]
        case (i_analog_gate_config)
            ifr_pkg::IFR_AG_ALWAYS: begin
                state_next.analog_active = 1'h1; // [R20]
            end
            ifr_pkg::IFR_AG_WHEN_LOW: begin
                state_next.analog_active = ~gate_in; // [R20]
            end
            ifr_pkg::IFR_AG_WHEN_HIGH: begin
                state_next.analog_active = gate_in; // [R20]
            end
            // Undefined setting falls back to always active
            default: begin
                state_next.analog_active = 1'h1;
            end
        endcase

        // ****************************************
        // Autoset
        // ****************************************
        // Edge only, whatever the trigger mode
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_AUTOSET, i_board_fitted);
        state_next.autoset_pulse = fn_any(m, rise); // [R13]

        // ****************************************
        // Spin brake
        // ****************************************
        // Not gated by run state: accepted while stopped and still rotating
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_SPIN_BRAKE, i_board_fitted);
        state_next.spin_brake_req = fn_any(m, lvl); // [R14]

        // ****************************************
        // External alarms
        // ****************************************
        // Active low, so an open input trips
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_ALARM1, i_board_fitted);
        state_next.alarm1 = fn_any(m, ~lvl); // [R15]
        m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_ALARM2, i_board_fitted);
        state_next.alarm2 = fn_any(m, ~lvl); // [R16]

        // ****************************************
        // Timer starts
        // ****************************************
        // Rising edges only, one cycle each
        for (int t = 0; t < ifr_pkg::IFR_NUM_TIMERS; t++) begin
            m = fn_mask(state_reg.sel, ifr_pkg::IFR_FN_TIMER1 + ifr_pkg::IFR_CODE_W'(t),
                i_board_fitted);
            state_next.timer_start[t] = fn_any(m, rise); // [R17]
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
            state_reg.sel[0] <= ifr_pkg::IFR_DEF_SEL0; // [R3]
            state_reg.sel[1] <= ifr_pkg::IFR_DEF_SEL1; // [R19]
            state_reg.sel[2] <= ifr_pkg::IFR_DEF_SEL2; // [R19]
            state_reg.sel[3] <= ifr_pkg::IFR_DEF_SEL3; // [R19]
            // Board selectors start unused, so a late-fitted board does nothing
            for (int i = ifr_pkg::IFR_NUM_BASE; i < ifr_pkg::IFR_NUM_IN; i++) begin
                state_reg.sel[i] <= ifr_pkg::IFR_DEF_SEL_BOARD;
            end
            // Enable starts set: defaults carry no enable input
            state_reg.enable <= ifr_pkg::IFR_RST_ENABLE; // [R7]
            state_reg.analog_active <= ifr_pkg::IFR_RST_ANALOG;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Straight from the flops, so no glitch reaches the consumers
    assign o_stop_req = state_reg.stop_req;
    assign o_trip_reset_pulse = state_reg.trip_reset_pulse;
    assign o_auto_reset_req = state_reg.auto_reset_req;
    assign o_enable = state_reg.enable;
    assign o_run_forward_cmd = state_reg.run_forward_cmd;
    assign o_run_reverse_cmd = state_reg.run_reverse_cmd;
    assign o_inch_forward_cmd = state_reg.inch_fwd;
    assign o_inch_reverse_cmd = state_reg.inch_rev;
    assign o_param_set = state_reg.param_set;
    assign o_local_mode = state_reg.local_mode;
    assign o_analog_active = state_reg.analog_active;
    assign o_autoset_pulse = state_reg.autoset_pulse;
    assign o_spin_brake_req = state_reg.spin_brake_req;
    assign o_ext_alarm1 = state_reg.alarm1;
    assign o_ext_alarm2 = state_reg.alarm2;
    assign o_timer_start = state_reg.timer_start;

endmodule : ifr_input_function_router

// ==== verification/ifr_router_chk.sv ====
// Port-level assertions for the input function router.
`timescale 1ns/1ps

module ifr_router_chk (
    input wire logic i_sys_clk, // Clock
    input wire logic i_rst_n, // Reset, active low
    input wire logic [ifr_pkg::IFR_NUM_IN-1:0] i_discrete_input, // Input levels
    input wire logic [ifr_pkg::IFR_NUM_BOARDS-1:0] i_board_fitted, // Boards present
    input wire logic i_sel_wr, // Selector write
    input wire logic i_edge_mode, // Run edge mode
    input wire logic i_auto_reset_on, // Auto reset on
    input wire logic i_set_src_inputs, // Set source
    input wire logic [1:0] i_param_set_other, // Other set
    input wire logic [1:0] i_analog_gate_config, // Gate mode
    input wire logic o_stop_req, // Stop
    input wire logic o_trip_reset_pulse, // Trip reset pulse
    input wire logic o_auto_reset_req, // Auto reset
    input wire logic o_run_forward_cmd, // Run forward
    input wire logic o_run_reverse_cmd, // Run reverse
    input wire logic o_inch_forward_cmd, // Inch forward
    input wire logic o_inch_reverse_cmd, // Inch reverse
    input wire logic [1:0] o_param_set, // Parameter set
    input wire logic o_local_mode, // Local mode
    input wire logic o_analog_active, // Analogue active
    input wire logic o_autoset_pulse, // Autoset pulse
    input wire logic o_spin_brake_req, // Spin brake
    input wire logic o_ext_alarm1, // Alarm one
    input wire logic o_ext_alarm2, // Alarm two
    input wire logic [ifr_pkg::IFR_NUM_TIMERS-1:0] o_timer_start // Timer starts
);
    // ****************************************************************
    // Sequences and properties
    // ****************************************************************
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // No fresh edge can reach the outputs while this holds
    sequence s_quiet;
        $past(i_discrete_input, 2) == $past(i_discrete_input, 3) && !$past(i_sel_wr)
            && $stable(i_board_fitted);
    endsequence
    sequence s_all_high;
        (&i_discrete_input) [*3];
    endsequence
    sequence s_all_low;
        (i_discrete_input == '0) [*3];
    endsequence
    property p_single(s);
        s ##0 s_quiet |=> !s;
    endproperty
    property p_run_edge;
        i_edge_mode && $past(i_edge_mode) && o_run_forward_cmd ##0 s_quiet |=> !o_run_forward_cmd;
    endproperty

    a_trip_reset_pulse: assert property (p_single(o_trip_reset_pulse))
        else $error("trip reset pulse long");
    a_autoset_pulse: assert property (p_single(o_autoset_pulse))
        else $error("autoset pulse long");
    a_timer_start_pulse: assert property (p_single(|o_timer_start))
        else $error("timer pulse long");
    a_run_edge_pulse: assert property (p_run_edge)
        else $error("run pulse long");
    a_auto_reset_gate: assert property (o_auto_reset_req |-> $past(i_auto_reset_on))
        else $error("auto reset ungated");
    a_set_source: assert property ($past(i_rst_n) && !$past(i_set_src_inputs)
        |-> o_param_set == $past(i_param_set_other)) else $error("set source wrong");
    a_analog_always: assert property ($past(i_rst_n)
        && $past(i_analog_gate_config) == 2'h0 |-> o_analog_active)
        else $error("analogue not active");
    a_high_no_trip: assert property (s_all_high |=>
        !o_stop_req && !o_ext_alarm1 && !o_ext_alarm2)
        else $error("stop or alarm with inputs high");
    a_low_no_cmd: assert property (s_all_low |=> !(o_run_forward_cmd | o_run_reverse_cmd
        | o_inch_forward_cmd | o_inch_reverse_cmd | o_local_mode | o_spin_brake_req
        | o_trip_reset_pulse | o_autoset_pulse | o_auto_reset_req | (|o_timer_start)))
        else $error("command with inputs low");
endmodule : ifr_router_chk

// ==== verification/ifr_contacts_model.sv ====
// Field contacts wired to the discrete inputs.
`timescale 1ns/1ps

module ifr_contacts_model (
    input wire logic [9:0] i_want, // Contact closed
    input wire logic [9:0] i_open, // Wire broken
    output logic [9:0] o_contact // Level at the input
);
    // A broken wire reads low, so alarm inputs trip
    assign o_contact = i_want & ~i_open;
endmodule : ifr_contacts_model

// ==== verification/ifr_input_function_router_test.sv ====
// Self-checking bench for the input function router.
`timescale 1ns/1ps

module ifr_input_function_router_test;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, edge_m = 1'b0, auto_on = 1'b1, src = 1'b1;
    logic rot = 1'b0, stop, trp, arq, en, rf, rr, jf, jr, loc, ana, aset, spin, al1, al2;
    logic [9:0] want = '0, open_c = '0, din;
    logic [4:0] code = 5'h00;
    logic [3:0] idx = 4'h0, tmr;
    logic [1:0] fit = 2'h3, other = 2'h0, cfg = 2'h0, pset;
    int sel_q[10] = '{4, 1, 8, 2, 0, 0, 0, 0, 0, 0};
    int pc[7] = '{2, 12, 4, 18, 19, 20, 21};
    int error_cnt = 0, n_compared = 0;

    always #20 clk = ~clk;

    ifr_contacts_model ifr_contacts_model_inst (.i_want(want), .i_open(open_c), .o_contact(din));
    ifr_input_function_router ifr_input_function_router_inst (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_discrete_input(din), .i_board_fitted(fit),
        .i_sel_wr(wr), .i_sel_index(idx), .i_sel_code(code), .i_edge_mode(edge_m),
        .i_auto_reset_on(auto_on), .i_set_src_inputs(src), .i_param_set_other(other),
        .i_analog_gate_config(cfg), .i_motor_rotating(rot), .o_stop_req(stop),
        .o_trip_reset_pulse(trp), .o_auto_reset_req(arq), .o_enable(en),
        .o_run_forward_cmd(rf), .o_run_reverse_cmd(rr), .o_inch_forward_cmd(jf),
        .o_inch_reverse_cmd(jr), .o_param_set(pset), .o_local_mode(loc),
        .o_analog_active(ana), .o_autoset_pulse(aset), .o_spin_brake_req(spin),
        .o_ext_alarm1(al1), .o_ext_alarm2(al2), .o_timer_start(tmr)
    );

    // ****************************************************************
    // Reference model and helpers
    // ****************************************************************
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function logic [13:0] model();
        logic st, rs, ea, r4, r5, j6, j7, b8, b9, lc, g, sp, a1, a2, b;
        int c;
        {st, rs, r4, r5, j6, j7, b8, b9, lc, g, sp, a1, a2} = '0;
        ea = 1'b1;
        for (int i = 0; i < 10; i++) begin
            c = (i < 4 || fit[(i - 4) / 3]) ? sel_q[i] : 0;
            b = want[i] & ~open_c[i];
            st |= c == 1 && !b;
            rs |= c == 2 && b;
            ea &= c != 3 || b;
            r4 |= c == 4 && b;
            r5 |= c == 5 && b;
            j6 |= c == 6 && b;
            j7 |= c == 7 && b;
            b8 |= c == 8 && b;
            b9 |= c == 9 && b;
            lc |= c == 10 && b;
            g |= c == 11 && b;
            sp |= c == 13 && b;
            a1 |= c == 16 && !b;
            a2 |= c == 17 && !b;
        end
        return {st, rs && auto_on, ea, r4 && !edge_m, r5 && !edge_m, j6, j7,
            src ? {b9, b8} : other, lc, cfg == 1 ? !g : cfg == 2 ? g : 1'b1, sp, a1, a2};
    endfunction : model

    task cmp_levels();
        logic [13:0] seen;
        seen = {stop, arq, en, rf, rr, jf, jr, pset, loc, ana, spin, al1, al2};
        check("levels", seen, model());
    endtask : cmp_levels

    task wr_sel(int i, int c);
        @(posedge clk) #1;
        wr = 1'b1;
        idx = i[3:0];
        code = c[4:0];
        @(posedge clk) #1;
        wr = 1'b0;
        if (i < 10) sel_q[i] = c;
    endtask : wr_sel

    task settle();
        repeat (6) @(posedge clk);
        #2;
    endtask : settle

    function int pulse_of(int c);
        return c == 2 ? trp : c == 12 ? aset : c == 4 ? rf : tmr[c - 18];
    endfunction : pulse_of

    // Edge functions must pulse once; run forward is tried in edge mode, the rest with edge mode off
    task pulse_test(int c);
        int k, n;
        @(posedge clk) #1;
        k = $urandom % 10;
        n = 0;
        edge_m = (c == 4);
        want = '0;
        for (int i = 0; i < 10; i++) wr_sel(i, i == k ? c : 0);
        repeat (5) @(posedge clk);
        #1 want[k] = 1'h1;
        repeat (8) begin
            @(posedge clk) #2;
            n += pulse_of(c);
        end
        check("pulse count", n, 1);
    endtask : pulse_test

    task print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        void'($urandom(53045));
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        want = '1;
        settle();
        cmp_levels();
        $display("test defaults done");
        repeat (150) begin
            wr_sel($urandom % 16, $urandom % 22);
            wr_sel($urandom % 16, $urandom % 22);
            want = 10'($urandom);
            open_c = ($urandom % 4 == 0) ? 10'($urandom) : '0;
            {fit, edge_m, auto_on, src, other, cfg, rot} = 10'($urandom);
            settle();
            cmp_levels();
        end
        $display("test random mapping done");
        @(posedge clk) #1 fit = 2'h3;
        open_c = '0;
        foreach (pc[j]) pulse_test(pc[j]);
        $display("test edge pulses done");
        print_verdict();
    end

    // Run needs about 1750 cycles
    initial begin
        #400000;
        error_cnt++;
        print_verdict();
    end
endmodule : ifr_input_function_router_test

bind ifr_input_function_router ifr_router_chk ifr_router_chk_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_discrete_input(i_discrete_input),
    .i_board_fitted(i_board_fitted), .i_sel_wr(i_sel_wr), .i_edge_mode(i_edge_mode),
    .i_auto_reset_on(i_auto_reset_on), .i_set_src_inputs(i_set_src_inputs),
    .i_param_set_other(i_param_set_other), .i_analog_gate_config(i_analog_gate_config),
    .o_stop_req(o_stop_req), .o_trip_reset_pulse(o_trip_reset_pulse),
    .o_auto_reset_req(o_auto_reset_req), .o_run_forward_cmd(o_run_forward_cmd),
    .o_run_reverse_cmd(o_run_reverse_cmd), .o_inch_forward_cmd(o_inch_forward_cmd),
    .o_inch_reverse_cmd(o_inch_reverse_cmd), .o_param_set(o_param_set),
    .o_local_mode(o_local_mode), .o_analog_active(o_analog_active),
    .o_autoset_pulse(o_autoset_pulse), .o_spin_brake_req(o_spin_brake_req),
    .o_ext_alarm1(o_ext_alarm1), .o_ext_alarm2(o_ext_alarm2), .o_timer_start(o_timer_start)
);
